//--- logic/sgbms_pkg.sv
package sgbms_pkg;

    localparam logic [7:0] ADDR_TMO      = 8'h00;
    localparam logic [7:0] ADDR_PKT_CNT  = 8'h04;
    localparam logic [7:0] ADDR_DESC_USE = 8'h08;
    localparam logic [7:0] ADDR_LIST_USE = 8'h0c;
    localparam logic [7:0] ADDR_PACKET_ENGINE_STATUS = 8'h10;
    localparam logic [7:0] ADDR_DESC_LD  = 8'h14;
    localparam logic [7:0] ADDR_LIST_LD  = 8'h18;
    localparam logic [7:0] ADDR_MGR_STAT = 8'h1c;

    localparam int unsigned TICK_NS = 4;
    localparam int unsigned CLK_NS  = 100;
    localparam logic [16:0] TICKS_PER_CLK = 17'(CLK_NS / TICK_NS);
    localparam logic [16:0] ELAPSED_MAX   = 17'h1ffff;

    localparam logic [15:0] TMO_RST   = 16'hffff;
    localparam int unsigned TMO_DIS_B = 31;
    localparam int unsigned DROP_LSB  = 16;

    localparam int unsigned PS_NODESC = 8;
    localparam int unsigned PS_VDROP  = 9;
    localparam int unsigned PS_DDROP  = 10;
    localparam int unsigned PS_RDEMP  = 13;
    localparam int unsigned PS_WRFULL = 14;
    localparam int unsigned PS_FORCED = 16;

    localparam int unsigned MS_CODE_LSB = 4;
    localparam int unsigned MS_CACH_LSB = 8;
    localparam int unsigned MS_DEST     = 20;
    localparam int unsigned MS_NEXT     = 21;
    localparam int unsigned MS_SZMOD    = 22;
    localparam int unsigned MS_SZBIG    = 23;
    localparam int unsigned MS_CPLERR   = 28;
    localparam int unsigned MS_SEQ      = 29;
    localparam int unsigned MS_OVF      = 30;
    localparam int unsigned MS_EXPIRED  = 31;

    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONE  = 16'h0001;

    typedef enum logic [2:0] {
        MGR_IDLE     = 3'h0,
        MGR_ACTIVE   = 3'h1,
        MGR_REQ64    = 3'h2,
        MGR_REQ32    = 3'h3,
        MGR_WAIT_CPL = 3'h4,
        MGR_PARSE0   = 3'h5,
        MGR_PARSE1   = 3'h6,
        MGR_FLUSH    = 3'h7
    } sgbms_mgr_state_t;

    typedef enum logic [1:0] {
        PE_RESYNC  = 2'h0,
        PE_HEADER  = 2'h1,
        PE_PAYLOAD = 2'h2,
        PE_RSVD    = 2'h3
    } sgbms_pe_state_t;

    // One-cycle event pulses from the packet engine and fetch logic
    typedef struct packed {
        logic pkt_sent;
        logic pkt_dropped;
        logic desc_consumed;
        logic list_consumed;
        logic desc_loaded;
        logic list_loaded;
        logic no_desc;
        logic video_drop;
        logic desc_drop;
        logic fifo_rd_empty;
        logic fifo_wr_full;
        logic forced_send;
    } sgbms_events_t;

    // Level status from the fetch manager
    typedef struct packed {
        sgbms_mgr_state_t manager_state;
        logic [2:0]       last_completion_code;
        logic [7:0]       cached_descriptor_count;
        logic             dest_misaligned;
        logic             next_misaligned;
        logic             size_not_mod16;
        logic             size_over_4k;
        logic             completion_error;
        logic             sequence_mismatch;
        logic             cache_overflow;
        logic             completion_return;
    } sgbms_mgr_t;

endpackage

//--- logic/sgbms_top.sv
`timescale 1ns/1ps
module sgbms_top
    import sgbms_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    // APB slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [7:0]      paddr,
    input  wire logic [31:0]     pwdata,
    output logic                 pready,
    output logic [31:0]          prdata,
    output logic                 pslverr,
    // Engine status inputs
    input  wire sgbms_events_t   events,
    input  wire sgbms_mgr_t      mgr,
    input  wire sgbms_pe_state_t packet_engine_state,
    // Timeout control toward the fetch manager
    output logic [15:0]          timeout_value,
    output logic                 timeout_disable,
    output logic                 completion_wait_expired
);

    function automatic logic [15:0] inc16(input logic [15:0] v);
        inc16 = v + CNT_ONE;
    endfunction

    // Access-phase write strobe for one offset
    function automatic logic wr_hit(input logic [7:0] a);
        wr_hit = psel && penable && pwrite && paddr == a;
    endfunction

    logic        rst_m_q;
    logic        rst_s_b;
    logic [15:0] sent_q;
    logic [15:0] drop_q;
    logic [15:0] desc_use_q;
    logic [15:0] list_use_q;
    logic [15:0] desc_ld_q;
    logic [15:0] list_ld_q;
    logic [15:0] tmo_q;
    logic        tmo_dis_q;
    logic [16:0] elapsed_q;
    logic        fired_q;
    logic        expired_q;
    logic        expired_flag_q;
    logic [31:0] packet_engine_status_q;
    logic [31:0] mgr_stat_q;
    logic        tmo_reached;
    logic        rd_setup;
    logic [31:0] rd_d;
    logic        err_d;

    // Reset release through two flops
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rst_m_q <= 1'b0;
            rst_s_b <= 1'b0;
        end
        else
        begin
            rst_m_q <= 1'b1;
            rst_s_b <= rst_m_q;
        end
    end

    assign rd_setup    = psel && !penable;
    assign tmo_reached = elapsed_q >= {1'b0, tmo_q};

    // Timeout control register
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            tmo_q     <= TMO_RST;
            tmo_dis_q <= 1'b0;
        end
        else if (wr_hit(ADDR_TMO) && mgr.manager_state == MGR_IDLE)
        begin
            tmo_q     <= pwdata[15:0];
            tmo_dis_q <= pwdata[TMO_DIS_B];
        end
    end

    // Elapsed time in 4 ns ticks; saturates so a long wait cannot wrap
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            elapsed_q <= 17'h00000;
            fired_q   <= 1'b0;
            expired_q <= 1'b0;
        end
        else if (mgr.manager_state != MGR_WAIT_CPL || mgr.completion_return)
        begin
            elapsed_q <= 17'h00000;
            fired_q   <= 1'b0;
            expired_q <= 1'b0;
        end
        else if (tmo_dis_q)
        begin
            expired_q <= 1'b0;
        end
        else
        begin
            if (elapsed_q <= ELAPSED_MAX - TICKS_PER_CLK)
            begin
                elapsed_q <= elapsed_q + TICKS_PER_CLK;
            end
            expired_q <= !fired_q && tmo_reached;
            if (tmo_reached)
            begin
                fired_q <= 1'b1;
            end
        end
    end

    // Expired flag holds until a timeout register write while the manager is idle
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            expired_flag_q <= 1'b0;
        end
        else if (expired_q)
        begin
            expired_flag_q <= 1'b1;
        end
        else if (mgr.manager_state == MGR_IDLE && wr_hit(ADDR_TMO))
        begin
            expired_flag_q <= 1'b0;
        end
    end

    // Sent packet counter
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            sent_q <= CNT_ZERO;
        end
        else
        begin
            if (events.pkt_sent)
            begin
                sent_q <= inc16(sent_q);
            end
        end
    end

    // Descriptor and list counters
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            desc_use_q <= CNT_ZERO;
            list_use_q <= CNT_ZERO;
        end
        else
        begin
            if (events.desc_consumed)
            begin
                desc_use_q <= inc16(desc_use_q);
            end
            if (events.list_consumed)
            begin
                list_use_q <= inc16(list_use_q);
            end
        end
    end

    // Loaded descriptor and list counters
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            desc_ld_q <= CNT_ZERO;
            list_ld_q <= CNT_ZERO;
        end
        else
        begin
            if (events.desc_loaded)
            begin
                desc_ld_q <= inc16(desc_ld_q);
            end
            if (events.list_loaded)
            begin
                list_ld_q <= inc16(list_ld_q);
            end
        end
    end

    // Dropped packet counter, independent of the sent count
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            drop_q <= CNT_ZERO;
        end
        else if (events.pkt_dropped)
        begin
            drop_q <= inc16(drop_q);
        end
    end

    // Packet engine status; sticky flags, set beats a same-cycle clear
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            packet_engine_status_q <= '0;
        end
        else
        begin
            packet_engine_status_q[1:0] <= packet_engine_state;
            if (wr_hit(ADDR_PACKET_ENGINE_STATUS))
            begin
                if (pwdata[PS_WRFULL])
                begin
                    packet_engine_status_q[PS_WRFULL] <= 1'b0;
                end
                if (pwdata[PS_FORCED])
                begin
                    packet_engine_status_q[PS_FORCED] <= 1'b0;
                end
            end
            if (events.no_desc)
            begin
                packet_engine_status_q[PS_NODESC] <= 1'b1;
            end
            if (events.video_drop && packet_engine_state == PE_RESYNC)
            begin
                packet_engine_status_q[PS_VDROP] <= 1'b1;
            end
            if (events.desc_drop && packet_engine_state == PE_RESYNC)
            begin
                packet_engine_status_q[PS_DDROP] <= 1'b1;
            end
            if (events.fifo_rd_empty)
            begin
                packet_engine_status_q[PS_RDEMP] <= 1'b1;
            end
            if (events.fifo_wr_full)
            begin
                packet_engine_status_q[PS_WRFULL] <= 1'b1;
            end
            if (events.forced_send)
            begin
                packet_engine_status_q[PS_FORCED] <= 1'b1;
            end
        end
    end

    // Fetch manager status snapshot, one cycle behind the inputs
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            mgr_stat_q <= '0;
        end
        else
        begin
            mgr_stat_q <= '0;
            mgr_stat_q[2:0] <= mgr.manager_state;
            mgr_stat_q[MS_CODE_LSB +: 3] <= mgr.last_completion_code;
            mgr_stat_q[MS_CACH_LSB +: 8] <= mgr.cached_descriptor_count;
            mgr_stat_q[MS_DEST] <= mgr.dest_misaligned;
            mgr_stat_q[MS_NEXT] <= mgr.next_misaligned;
            mgr_stat_q[MS_SZMOD] <= mgr.size_not_mod16;
            mgr_stat_q[MS_SZBIG] <= mgr.size_over_4k;
            mgr_stat_q[MS_CPLERR]  <= mgr.completion_error;
            mgr_stat_q[MS_SEQ]     <= mgr.sequence_mismatch;
            mgr_stat_q[MS_OVF]     <= mgr.cache_overflow;
            mgr_stat_q[MS_EXPIRED] <= expired_flag_q || expired_q;
        end
    end

    // Read mux; data is captured in the setup cycle for zero wait states
    always_comb
    begin
        rd_d  = '0;
        err_d = 1'b0;
        case (paddr)
            ADDR_TMO:
            begin
                rd_d[15:0]      = tmo_q;
                rd_d[TMO_DIS_B] = tmo_dis_q;
            end
            ADDR_PKT_CNT:
            begin
                rd_d = {drop_q, sent_q};
            end
            ADDR_DESC_USE: rd_d[15:0] = desc_use_q;
            ADDR_LIST_USE: rd_d[15:0] = list_use_q;
            ADDR_PACKET_ENGINE_STATUS: rd_d = packet_engine_status_q;
            ADDR_DESC_LD:  rd_d[15:0] = desc_ld_q;
            ADDR_LIST_LD:  rd_d[15:0] = list_ld_q;
            ADDR_MGR_STAT: rd_d = mgr_stat_q;
            default:       err_d = 1'b1;
        endcase
    end

    // APB answer
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            pready  <= 1'b0;
            prdata  <= '0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= 1'b1;
            if (rd_setup)
            begin
                prdata  <= pwrite ? 32'h0000_0000 : rd_d;
                pslverr <= err_d;
            end
        end
    end

    // Control outputs
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            timeout_value           <= TMO_RST;
            timeout_disable         <= 1'b0;
        end
        else
        begin
            timeout_value           <= tmo_q;
            timeout_disable         <= tmo_dis_q;
        end
    end

    // Expiry pulse toward the fetch manager
    always_ff @(posedge clk or negedge rst_s_b)
    begin
        if (!rst_s_b)
        begin
            completion_wait_expired <= 1'b0;
        end
        else
        begin
            completion_wait_expired <= expired_q;
        end
    end

endmodule

//--- tb/sgbms_monitor.sv
`timescale 1ns/1ps
module sgbms_monitor
    import sgbms_pkg::*;
(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst_b,
    // Bus
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Manager side
    input wire sgbms_mgr_t  mgr,
    input wire logic [15:0] timeout_value,
    input wire logic        timeout_disable,
    input wire logic        completion_wait_expired
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);

    logic tmo_wr;
    logic idle;
    logic waiting;
    assign tmo_wr  = psel && penable && pwrite && pready && paddr == ADDR_TMO;
    assign idle    = mgr.manager_state == MGR_IDLE;
    assign waiting = mgr.manager_state == MGR_WAIT_CPL && !mgr.completion_return;

    // Wait of 25 ticks starts, one clock covers it
    sequence s_wait_start;
        !waiting ##1 waiting && timeout_value == 16'h0019 && !timeout_disable;
    endsequence
    sequence s_wait_hold;
        waiting [*2];
    endsequence

    a_pready_up: assert property ($rose(rst_b) |-> ##[2:3] pready)
        else $error("bus never ready");
    a_pready_hold: assert property (pready |=> pready)
        else $error("ready dropped");
    a_err_unmapped: assert property (psel && !penable && (paddr > ADDR_MGR_STAT
        || paddr[1:0] != 2'h0) |=> pslverr)
        else $error("no error on unmapped address");
    a_tmo_idle_wr: assert property (
        tmo_wr && idle |-> ##2 timeout_value == $past(pwdata[15:0], 2))
        else $error("timeout write lost");
    a_tmo_busy_wr: assert property (
        tmo_wr && !idle |=> $stable(timeout_value) [*2])
        else $error("timeout changed while busy");
    a_tmo_disabled: assert property (
        timeout_disable && $past(timeout_disable) |-> !completion_wait_expired)
        else $error("expiry while disabled");
    a_expire_once: assert property (
        completion_wait_expired |=> !completion_wait_expired)
        else $error("expiry pulse too long");
    a_expire_cause: assert property (
        completion_wait_expired |-> $past(mgr.manager_state, 2) == MGR_WAIT_CPL)
        else $error("expiry outside a wait");
    a_expire_time: assert property (
        s_wait_start ##1 s_wait_hold |=> completion_wait_expired)
        else $error("expiry late");
endmodule

bind sgbms_top sgbms_monitor mon (.clk(clk), .rst_b(rst_b), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .pslverr(pslverr), .mgr(mgr), .timeout_value(timeout_value),
    .timeout_disable(timeout_disable), .completion_wait_expired(completion_wait_expired));

//--- tb/sgbms_far_model.sv
`timescale 1ns/1ps
module sgbms_far_model
    import sgbms_pkg::*;
(
    // Clock and reset
    input  wire logic            clk,
    input  wire logic            rst_b,
    // Requests from the bench
    input  wire sgbms_events_t   ev_req,
    input  wire sgbms_mgr_t      mgr_req,
    input  wire sgbms_pe_state_t pe_req,
    // Toward the block
    output sgbms_events_t        events,
    output sgbms_mgr_t           mgr,
    output sgbms_pe_state_t      packet_engine_state
);
    // Registered so pulses leave on a clean edge
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            events              <= '0;
            mgr                 <= '0;
            packet_engine_state <= PE_RESYNC;
        end
        else
        begin
            events              <= ev_req;
            mgr                 <= mgr_req;
            packet_engine_state <= pe_req;
        end
    end
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, g) \
    begin n_compared++; if ((g) !== (e)) begin fail_count++; \
    $display("ERROR %s exp %h got %h", n, e, g); end end
module tb_top
    import sgbms_pkg::*;
;
    logic            clk     = 1'b0;
    logic            rst_b   = 1'b0;
    logic            psel    = 1'b0;
    logic            penable = 1'b0;
    logic            pwrite  = 1'b0;
    logic [7:0]      paddr   = 8'h00;
    logic [31:0]     pwdata  = 32'h0;
    logic [31:0]     seed    = 32'ha6d041ec;
    sgbms_events_t   ev_req  = '0;
    sgbms_mgr_t      mgr_req = '0;
    sgbms_pe_state_t pe_req  = PE_RESYNC;
    logic [31:0]     prdata, rd, pf;
    logic [15:0]     tval, timeout_value;
    logic [1:0]      p;
    logic            pready, pslverr, er, tmo_dis, exp_flag;
    logic            timeout_disable, completion_wait_expired;
    sgbms_events_t   events;
    sgbms_mgr_t      mgr;
    sgbms_pe_state_t pe;
    int              cnt [6];
    int              fail_count = 0;
    int              n_compared = 0;
    int              k;

    always #50 clk = ~clk;

    sgbms_far_model far (.clk(clk), .rst_b(rst_b), .ev_req(ev_req), .mgr_req(mgr_req),
        .pe_req(pe_req), .events(events), .mgr(mgr), .packet_engine_state(pe));
    sgbms_top dut (.clk(clk), .rst_b(rst_b), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .events(events), .mgr(mgr),
        .packet_engine_state(pe), .timeout_value(timeout_value),
        .timeout_disable(timeout_disable), .completion_wait_expired(completion_wait_expired));

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic logic [31:0] exp_reg(int i);
        sgbms_mgr_t m;
        m = mgr_req;
        case (i)
            0: return {tmo_dis, 15'h0, tval};
            1: return {16'(cnt[1]), 16'(cnt[0])};
            4: return pf | 32'(pe_req);
            7: return {exp_flag, m.cache_overflow, m.sequence_mismatch, m.completion_error,
                4'h0, m.size_over_4k, m.size_not_mod16, m.next_misaligned,
                m.dest_misaligned, 4'h0, m.cached_descriptor_count, 1'b0,
                m.last_completion_code, 1'b0, m.manager_state};
            default: return {16'h0, 16'(cnt[i > 4 ? i - 1 : i])};
        endcase
    endfunction

    task close_out;
        $display("compared %0d mismatched %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (k >= 50)
        begin
            fail_count++;
            close_out();
        end
    endtask

    task check_all;
        for (int i = 0; i < 8; i++)
        begin
            apb(1'b0, 8'(4 * i), 32'h0);
            `CHK("read_error", 1'b0, er)
            case (i)
                0: `CHK("timeout_reg", exp_reg(i), rd)
                1: `CHK("packet_counts", exp_reg(i), rd)
                2, 3: `CHK("consumed_counts", exp_reg(i), rd)
                4: `CHK("packet_status", exp_reg(i), rd)
                5, 6: `CHK("loaded_counts", exp_reg(i), rd)
                default: `CHK("manager_status", exp_reg(i), rd)
            endcase
        end
    endtask

    initial
    begin
        tval = TMO_RST;
        {tmo_dis, exp_flag, pf} = '0;
        for (int j = 0; j < 6; j++) cnt[j] = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        check_all();
        // Random pulses, engine state and manager levels
        repeat (40)
        begin
            rd = xs();
            p = rd[13:12] == 2'h3 ? 2'h0 : rd[13:12];
            ev_req  <= sgbms_events_t'(rd[11:0]);
            pe_req  <= sgbms_pe_state_t'(p);
            mgr_req <= sgbms_mgr_t'({rd[31:11], 1'b0});
            for (int j = 0; j < 6; j++) cnt[j] += rd[11 - j];
            pf |= {15'h0, rd[0], 1'b0, rd[1], rd[2], 2'h0, rd[3] && p == 2'h0,
                rd[4] && p == 2'h0, rd[5], 8'h0};
            @(posedge clk);
            ev_req <= '0;
            @(posedge clk);
        end
        repeat (3) @(posedge clk);
        check_all();
        // write one clears; read-only write ignored
        apb(1'b1, ADDR_PACKET_ENGINE_STATUS, 32'h0001_4000);
        pf &= ~32'h0001_4000;
        apb(1'b1, ADDR_PKT_CNT, 32'hffff_ffff);
        check_all();
        apb(1'b0, 8'h20, 32'h0);
        `CHK("unmapped_err", 1'b1, er)
        mgr_req <= sgbms_mgr_t'({MGR_ACTIVE, 19'h0});
        repeat (3) @(posedge clk);
        apb(1'b1, ADDR_TMO, 32'h8000_1234);
        check_all();
        mgr_req <= '0;
        repeat (3) @(posedge clk);
        apb(1'b1, ADDR_TMO, 32'h0000_0019);
        tval = 16'h0019;
        @(posedge clk);
        `CHK("timeout_value", tval, timeout_value)
        mgr_req.manager_state <= MGR_WAIT_CPL;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (completion_wait_expired !== 1'b1 && k < 100);
        `CHK("expire_edges", (25 + 24) / 25 + 4, k)
        mgr_req  <= '0;
        exp_flag = 1'b1;
        repeat (3) @(posedge clk);
        check_all();
        apb(1'b1, ADDR_TMO, 32'h8000_0019);
        {tmo_dis, exp_flag} = 2'b10;
        mgr_req.manager_state <= MGR_WAIT_CPL;
        k = 0;
        repeat (30)
        begin
            @(posedge clk);
            if (completion_wait_expired !== 1'b0) k++;
        end
        `CHK("quiet_wait", 0, k)
        `CHK("timeout_disable", 1'b1, timeout_disable)
        mgr_req <= '0;
        // sent count wraps past its top
        ev_req <= sgbms_events_t'(12'h800);
        repeat (65537) @(posedge clk);
        ev_req <= '0;
        cnt[0] += 65537;
        repeat (3) @(posedge clk);
        check_all();
        // Mid-run reset must bring every counter back to zero
        rst_b <= 1'b0;
        repeat (4) @(posedge clk);
        rst_b <= 1'b1;
        tval = TMO_RST;
        {tmo_dis, pf} = '0;
        for (int j = 0; j < 6; j++) cnt[j] = 0;
        repeat (8) @(posedge clk);
        `CHK("timeout_value", TMO_RST, timeout_value)
        check_all();
        close_out();
    end
endmodule
